// ==== rtl/acf_buf.sv ====
// Two-entry output buffer with valid and ready on both sides.
// Assumes one clock; outputs come from flip-flops.
`timescale 1ns/1ns
module acf_buf (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire acf_pkg::acf_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output acf_pkg::acf_word_t out_word
);
  import acf_pkg::*;

  acf_word_t head_reg;
  acf_word_t tail_reg;
  logic head_v_reg;
  logic tail_v_reg;
  logic push;
  logic pop;

  assign push = in_valid & ~tail_v_reg;
  assign pop = head_v_reg & out_ready;
  assign in_ready = ~tail_v_reg;
  assign out_valid = head_v_reg;
  assign out_word = head_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
    end else if (pop) begin
      head_v_reg <= tail_v_reg | push;
      tail_v_reg <= tail_v_reg & push;
    end else if (push) begin
      head_v_reg <= 1'b1;
      tail_v_reg <= head_v_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      head_reg <= '0;
      tail_reg <= '0;
    end else if (pop) begin
      head_reg <= tail_v_reg ? tail_reg : in_word;
      if (tail_v_reg & push) begin
        tail_reg <= in_word;
      end
    end else if (push) begin
      if (head_v_reg) begin
        tail_reg <= in_word;
      end else begin
        head_reg <= in_word;
      end
    end
  end
endmodule

// ==== rtl/acf_defs.svh ====
// Constants for the sample clock divider and output formatter.
// Assumes inclusion by bare name from the package and the top module.
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH

`define ACF_ADDR_OUT_FMT 8'h01
`define ACF_ADDR_TIMING 8'h03
`define ACF_ADDR_CDFT 8'h06
`define ACF_ADDR_RSVD 8'h07
`define ACF_ADDR_CMODE 8'h08
`define ACF_ADDR_SWRST 8'h0A

`define ACF_RST_OUT_FMT 8'h00
`define ACF_RST_TIMING 8'hB6
`define ACF_RST_CDFT 8'h00
`define ACF_RST_CMODE 8'h00
`define ACF_SWRST_KEY 8'h5A

`define ACF_BIT_PATTERN 7
`define ACF_BIT_TEST_EN 6
`define ACF_FMT_HI 5
`define ACF_FMT_LO 4
`define ACF_BIT_TERM 3
`define ACF_BIT_SYNC_MODE 2
`define ACF_DIV_HI 1
`define ACF_DIV_LO 0
`define ACF_BIT_MUX 1
`define ACF_BIT_BYPASS 7
`define ACF_BIT_HALF 6
`define ACF_CLKT_HI 5
`define ACF_CLKT_LO 3
`define ACF_DT_HI 2
`define ACF_DT_LO 0

`define ACF_FMT_TWOS_A 2'h0
`define ACF_FMT_OFFSET 2'h1
`define ACF_FMT_GRAY 2'h2
`define ACF_DIV_NONE 2'h0
`define ACF_DIV_2 2'h1
`define ACF_DIV_4 2'h2

`define ACF_RAMP_MAX 10'h3FF
`define ACF_ALT_HI 10'h155
`define ACF_ALT_LO 10'h2AA
`define ACF_LATENCY 9
`define ACF_ALIGNER_PS 12'hD48
`define ACF_HALF_T_16 5'sh08
`define ACF_CLK_LEAD_16 5'sh02

`endif

// ==== rtl/acf_pkg.sv ====
// Types shared by the formatter top and its output buffer.
// Assumes acf_defs.svh is on the include path.
package acf_pkg;
  `include "acf_defs.svh"

  typedef struct packed {
    logic over_a;
    logic [9:0] data_a;
    logic over_b;
    logic [9:0] data_b;
  } acf_word_t;

  typedef enum logic [1:0] {SY_IDLE, SY_WAIT2, SY_WAIT3} acf_sync_t;

  // Delay code to signed sixteenths of a period, reserved code as nominal
  function automatic logic signed [4:0] acf_dec(input logic [2:0] code);
    logic signed [4:0] mag;
    mag = $signed({3'h0, code[1:0]});
    acf_dec = code[2] ? -mag : mag;
  endfunction
endpackage

// ==== rtl/acf_top.sv ====
// Sample clock divider, test patterns, output format and output timing.
// Assumes the converter core gives offset binary words each sys_clk edge.
// Contract
// [RULE1] Ramp pattern counts 0 to 1023 offset binary, repeats, then formatted.
// [RULE2] Alternating pattern toggles 0101010101 flag set, 1010101010 clear.
// [RULE3] Test enable one replaces samples with pattern; zero passes data.
// [RULE4] Format 00,11 two's complement, 01 offset binary, 10 Gray; reset 00.
// [RULE5] Sync mode bit 0 slip, 1 edge; reset value 0.
// [RULE6] Divider 00,11 none, 01 by two, 10 by four; reset 00.
// [RULE7] Writing 5Ah to reset key register restores all configuration.
// [RULE8] Host never writes reserved register 07h.
// [RULE9] Serial port enable high takes divider ratio from pins.
// [RULE10] Each sample is taken on divided clock rising edge.
// [RULE11] Output word appears after nine sample clock cycles.
// [RULE12] With division, sampling and latency use the divided clock.
// [RULE13] Slip mode skips one divider step on third edge after sync.
// [RULE14] Edge mode forces divider state zero on third edge after sync.
// [RULE15] Edge mode divided rise on fourth edge by two, fifth by four.
// [RULE16] Controller picks sync mode first, then raises sync input.
// [RULE17] Aligner bypass shortens data and clock delay by about 3.4ns.
// [RULE18] Half period delay adds T/2, not in multiplexed bus mode.
// [RULE19] Data delay field shifts data timing in T/16 steps.
// [RULE20] Clock delay field T/16 steps; equal codes lead data by T/8.
// [RULE21] Delay codes 000 nominal, 001-011 plus, 101-111 minus; 100 reserved.
// [RULE22] With bypass, host keeps clock delay code not later than data.
// [RULE23] Sync edge found by sampling sync each edge, counting from first high.
// [RULE24] Ratio, format and test mode change only at sample boundaries.
`timescale 1ns/1ns
`include "acf_defs.svh"
module acf_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic serial_port_enable,
  input wire logic divider_select_hi,
  input wire logic divider_select_lo,
  input wire logic sync_in,
  input wire acf_pkg::acf_word_t conv_word,
  output logic sample_taken,
  output logic sample_stall,
  output acf_pkg::acf_word_t out_word,
  output logic out_valid,
  input wire logic out_ready,
  output logic output_clock,
  output logic signed [4:0] data_shift_16,
  output logic signed [4:0] outclk_shift_16,
  output logic [11:0] aligner_delay_ps,
  output logic clk_term_en,
  output logic [7:0] common_mode_cfg
);
  import acf_pkg::*;

  logic [7:0] out_fmt_reg;
  logic [7:0] timing_reg;
  logic [7:0] cdft_reg;
  logic [7:0] cmode_reg;
  logic swrst_reg;
  logic [7:0] live_reg;
  logic [1:0] ratio_reg;
  logic [1:0] div_cnt_reg;
  logic [1:0] div_cnt_next;
  logic div_clk_reg;
  logic div_clk_next;
  logic sync_prev_reg;
  acf_sync_t sync_state_reg;
  logic sync_act;
  logic tick;
  logic adv;
  logic [9:0] ramp_reg;
  logic alt_reg;
  acf_word_t raw_word;
  acf_word_t fmt_word;
  acf_word_t pipe_reg [0:`ACF_LATENCY-1];
  logic [`ACF_LATENCY-1:0] fill_reg;
  logic buf_in_ready;
  logic buf_valid;
  acf_word_t buf_word;
  logic [1:0] ratio_sel;
  logic wr_cfg;

  // Register writes; the reserved offset is left unwritten
  assign wr_cfg = reg_wr_en & (reg_addr != `ACF_ADDR_RSVD); // [RULE8]

  always_ff @(posedge sys_clk) begin
    if (rst | swrst_reg) begin // [RULE7]
      out_fmt_reg <= `ACF_RST_OUT_FMT;
      timing_reg <= `ACF_RST_TIMING;
      cdft_reg <= `ACF_RST_CDFT; // [RULE4] [RULE5] [RULE6]
      cmode_reg <= `ACF_RST_CMODE;
    end else if (wr_cfg) begin
      case (reg_addr)
        `ACF_ADDR_OUT_FMT: begin
          out_fmt_reg <= reg_wdata;
        end
        `ACF_ADDR_TIMING: begin
          timing_reg <= reg_wdata;
        end
        `ACF_ADDR_CDFT: begin
          cdft_reg <= reg_wdata;
        end
        `ACF_ADDR_CMODE: begin
          cmode_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Key write starts the configuration reset on the next edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      swrst_reg <= 1'b0;
    end else begin
      swrst_reg <= reg_wr_en & (reg_addr == `ACF_ADDR_SWRST) &
                   (reg_wdata == `ACF_SWRST_KEY); // [RULE7]
    end
  end

  // Read data; key and reserved offsets read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `ACF_ADDR_OUT_FMT: begin
          reg_rdata <= out_fmt_reg;
        end
        `ACF_ADDR_TIMING: begin
          reg_rdata <= timing_reg;
        end
        `ACF_ADDR_CDFT: begin
          reg_rdata <= cdft_reg;
        end
        `ACF_ADDR_CMODE: begin
          reg_rdata <= cmode_reg;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // Sync rising edge is edge one; the third edge acts on the divider
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_prev_reg <= 1'b0;
      sync_state_reg <= SY_IDLE;
    end else begin
      sync_prev_reg <= sync_in; // [RULE23]
      case (sync_state_reg)
        SY_IDLE: begin
          if (sync_in & ~sync_prev_reg) begin
            sync_state_reg <= SY_WAIT2; // [RULE23]
          end
        end
        SY_WAIT2: begin
          sync_state_reg <= SY_WAIT3;
        end
        SY_WAIT3: begin
          sync_state_reg <= SY_IDLE;
        end
        default: begin
          sync_state_reg <= SY_IDLE;
        end
      endcase
    end
  end

  assign sync_act = (sync_state_reg == SY_WAIT3);

  // Divider ratio source: pins when strapped, else the live register copy
  assign ratio_sel = serial_port_enable ?
                     {divider_select_hi, divider_select_lo} :
                     live_reg[`ACF_DIV_HI:`ACF_DIV_LO]; // [RULE9]

  always_comb begin
    if (sync_act & live_reg[`ACF_BIT_SYNC_MODE]) begin
      div_cnt_next = 2'h0; // [RULE14] [RULE5]
    end else if (sync_act) begin
      div_cnt_next = div_cnt_reg; // [RULE13]
    end else begin
      case (ratio_reg)
        `ACF_DIV_2: begin
          div_cnt_next = {1'b0, ~div_cnt_reg[0]}; // [RULE6]
        end
        `ACF_DIV_4: begin
          div_cnt_next = div_cnt_reg + 2'h1; // [RULE6]
        end
        default: begin
          div_cnt_next = 2'h0; // [RULE6]
        end
      endcase
    end
    case (ratio_reg)
      `ACF_DIV_2: begin
        div_clk_next = div_cnt_next[0]; // [RULE15]
      end
      `ACF_DIV_4: begin
        div_clk_next = div_cnt_next[1]; // [RULE15]
      end
      default: begin
        div_clk_next = 1'b1;
      end
    endcase
  end

  // One tick per divided clock rising edge; every edge when undivided
  assign tick = ((ratio_reg != `ACF_DIV_2) & (ratio_reg != `ACF_DIV_4)) |
                (div_clk_next & ~div_clk_reg); // [RULE12]
  assign adv = tick & buf_in_ready;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_reg <= 2'h0;
      div_clk_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      div_clk_reg <= div_clk_next;
    end
  end

  // Mode fields follow the registers only at sample boundaries
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      live_reg <= `ACF_RST_CDFT;
      ratio_reg <= `ACF_DIV_NONE;
    end else if (tick) begin
      live_reg <= cdft_reg; // [RULE24]
      ratio_reg <= ratio_sel; // [RULE24] [RULE9]
    end
  end

  // Test pattern generators advance once per taken sample
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ramp_reg <= 10'h000;
      alt_reg <= 1'b0;
    end else if (adv) begin
      ramp_reg <= (ramp_reg == `ACF_RAMP_MAX) ? 10'h000 :
                  ramp_reg + 10'h001; // [RULE1]
      alt_reg <= ~alt_reg; // [RULE2]
    end
  end

  always_comb begin
    raw_word = conv_word;
    if (live_reg[`ACF_BIT_TEST_EN]) begin // [RULE3]
      if (live_reg[`ACF_BIT_PATTERN]) begin
        raw_word.data_a = alt_reg ? `ACF_ALT_LO : `ACF_ALT_HI; // [RULE2]
        raw_word.data_b = alt_reg ? `ACF_ALT_LO : `ACF_ALT_HI;
        raw_word.over_a = ~alt_reg;
        raw_word.over_b = ~alt_reg;
      end else begin
        raw_word.data_a = ramp_reg; // [RULE1]
        raw_word.data_b = ramp_reg;
        raw_word.over_a = 1'b0;
        raw_word.over_b = 1'b0;
      end
    end
    fmt_word = raw_word;
    case (live_reg[`ACF_FMT_HI:`ACF_FMT_LO])
      `ACF_FMT_OFFSET: begin
        fmt_word = raw_word; // [RULE4]
      end
      `ACF_FMT_GRAY: begin
        fmt_word.data_a = raw_word.data_a ^ (raw_word.data_a >> 1); // [RULE4]
        fmt_word.data_b = raw_word.data_b ^ (raw_word.data_b >> 1);
      end
      default: begin
        fmt_word.data_a = {~raw_word.data_a[9], raw_word.data_a[8:0]};
        fmt_word.data_b = {~raw_word.data_b[9], raw_word.data_b[8:0]};
      end
    endcase
  end

  // Nine-stage sample pipeline clocked by the divided sample tick while the output buffer has room
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pipe_reg[0] <= '0;
      fill_reg[0] <= 1'b0;
    end else if (adv) begin
      pipe_reg[0] <= fmt_word; // [RULE10]
      fill_reg[0] <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < `ACF_LATENCY; gi = gi + 1) begin : g_pipe
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pipe_reg[gi] <= '0;
          fill_reg[gi] <= 1'b0;
        end else if (adv) begin
          pipe_reg[gi] <= pipe_reg[gi-1]; // [RULE11]
          fill_reg[gi] <= fill_reg[gi-1];
        end
      end
    end
  endgenerate

  acf_buf u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(adv & fill_reg[`ACF_LATENCY-1]), // [RULE11]
    .in_ready(buf_in_ready),
    .in_word(pipe_reg[`ACF_LATENCY-1]),
    .out_valid(buf_valid),
    .out_ready(out_ready),
    .out_word(buf_word)
  );

  assign out_word = buf_word;
  assign out_valid = buf_valid;

  // Sample strobes and output clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_taken <= 1'b0;
      sample_stall <= 1'b0;
      output_clock <= 1'b0;
    end else begin
      sample_taken <= adv; // [RULE10]
      sample_stall <= tick & ~buf_in_ready;
      output_clock <= div_clk_next;
    end
  end

  // Output timing controls: shifts decoded to sixteenths of a sample period, aligner delay in ps
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_shift_16 <= 5'sh00;
      outclk_shift_16 <= 5'sh00;
      aligner_delay_ps <= 12'h000;
      clk_term_en <= 1'b0;
      common_mode_cfg <= 8'h00;
    end else begin
      data_shift_16 <= acf_dec(timing_reg[`ACF_DT_HI:`ACF_DT_LO]) +
        ((timing_reg[`ACF_BIT_HALF] & ~out_fmt_reg[`ACF_BIT_MUX]) ?
         `ACF_HALF_T_16 : 5'sh00); // [RULE19] [RULE21] [RULE18]
      outclk_shift_16 <= acf_dec(timing_reg[`ACF_CLKT_HI:`ACF_CLKT_LO]) -
        `ACF_CLK_LEAD_16; // [RULE20] [RULE21]
      aligner_delay_ps <= timing_reg[`ACF_BIT_BYPASS] ? 12'h000 :
                          `ACF_ALIGNER_PS; // [RULE17]
      clk_term_en <= cdft_reg[`ACF_BIT_TERM];
      common_mode_cfg <= cmode_reg;
    end
  end
endmodule

// ==== sim/acf_chk_checker.sv ====
// Concurrent checks on the ports of the divider and formatter top.
// Assumes it is bound onto acf_top and sees its ports by name.
`timescale 1ns/1ns
module acf_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_port_enable,
  input wire logic divider_select_hi,
  input wire logic divider_select_lo,
  input wire logic sample_taken,
  input wire acf_pkg::acf_word_t out_word,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic signed [4:0] data_shift_16,
  input wire logic signed [4:0] outclk_shift_16,
  input wire logic [11:0] aligner_delay_ps
);
  import acf_pkg::*;
  logic w3;
  logic [7:0] t_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  function automatic logic signed [4:0] dec(input logic [2:0] c);
    logic signed [4:0] m;
    m = $signed({3'h0, c[1:0]});
    dec = c == 3'h4 ? 5'sh00 : (c[2] ? -m : m);
  endfunction
  assign w3 = reg_wr_en && reg_addr == 8'h03;
  // Last value written to the timing register
  always_ff @(posedge sys_clk) begin
    if (w3) begin
      t_reg <= reg_wdata;
    end
  end
  rsvd_reads_zero_a: assert property (
    reg_rd_en && (reg_addr == 8'h07 || reg_addr == 8'h0A)
    |=> reg_rdata == 8'h00) else $error("reserved read not zero");
  key_reset_a: assert property (
    reg_wr_en && reg_addr == 8'h0A && reg_wdata == 8'h5A
    ##1 !reg_wr_en [*3] ##1 reg_rd_en && reg_addr == 8'h06
    |=> reg_rdata == 8'h00) else $error("key write kept config");
  bypass_delay_a: assert property (
    w3 ##1 !reg_wr_en |=> aligner_delay_ps == (t_reg[7] ? 12'h000 : 12'hD48))
    else $error("aligner delay wrong");
  data_step_a: assert property (
    w3 && !reg_wdata[6] ##1 !reg_wr_en
    |=> data_shift_16 == dec(t_reg[2:0])) else $error("data shift wrong");
  clk_step_a: assert property (
    w3 ##1 !reg_wr_en |=> outclk_shift_16 == dec(t_reg[5:3]) - 5'sh02)
    else $error("clock shift wrong");
  word_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("word changed while stalled");
  pin_div2_a: assert property (
    (serial_port_enable && !divider_select_hi && divider_select_lo) [*8]
    ##0 sample_taken |=> !sample_taken) else $error("pin ratio two wrong");
  pin_div4_a: assert property (
    (serial_port_enable && divider_select_hi && !divider_select_lo) [*8]
    ##0 sample_taken |=> !sample_taken [*3])
    else $error("pin ratio four wrong");
endmodule

bind acf_top acf_chk u_chk (.*);

// ==== sim/acf_sink.sv ====
// Capturing logic model: pops formatted words, stalls on request.
// Assumes the bench drives hold; single clock shared with the top.
`timescale 1ns/1ns
module acf_sink (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hold,
  input wire acf_pkg::acf_word_t out_word,
  input wire logic out_valid,
  output logic out_ready,
  output acf_pkg::acf_word_t last_word
);
  import acf_pkg::*;
  initial out_ready = 1'b0;
  always @(posedge sys_clk) begin
    out_ready <= #1 !hold && !rst;
    if (out_valid && out_ready) begin
      last_word <= out_word;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the divider and formatter top.
// Assumes acf_sink as capturing logic and acf_chk bound to the top.
`timescale 1ns/1ns
module testbench;
  import acf_pkg::*;
  logic sys_clk, rst, reg_wr_en, reg_rd_en, serial_port_enable;
  logic divider_select_hi, divider_select_lo, sync_in, out_ready, hold;
  logic sample_taken, sample_stall, out_valid, output_clock, clk_term_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, common_mode_cfg;
  acf_word_t conv_word, out_word, last_word, w1;
  logic signed [4:0] data_shift_16, outclk_shift_16;
  logic [11:0] aligner_delay_ps;
  int fail_count, n_checks, n;
  logic [21:0] tim;
  logic [4:0] sv;
  assign tim = {aligner_delay_ps, data_shift_16, outclk_shift_16};
  acf_top u_dut (.*);
  acf_sink u_sink (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick(1);
    reg_rd_en = 1'b0;
    check(reg_rdata, exp);
    tick(1);
  endtask
  task automatic cnt(input int k);
    n = 0;
    repeat (k) begin
      tick(1);
      n += sample_taken;
    end
  endtask
  function automatic logic [9:0] fm(input logic [9:0] x, input logic [1:0] f);
    fm = f == 2'h1 ? x : (f == 2'h2 ? x ^ (x >> 1) : x ^ 10'h200);
  endfunction
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {reg_wr_en, reg_rd_en, serial_port_enable, sync_in, hold} = 5'h00;
    {divider_select_hi, divider_select_lo} = 2'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    conv_word = 22'h000000;
    tick(4);
    rst = 1'b0;
    rd(8'h06, 8'h00);
    rd(8'h03, 8'hB6);
    check(tim, 22'h0003DC);
    rd(8'h07, 8'h00);
    rd(8'h0B, 8'h00);
    wr(8'h08, 8'hA5);
    rd(8'h08, 8'hA5);
    check(common_mode_cfg, 8'hA5);
    wr(8'h03, 8'h4B);
    check(tim, 22'h35217F);
    wr(8'h03, 8'hF5);
    check(tim, 22'h0000FC);
    wr(8'h03, 8'h0D);
    check(tim, 22'h3523FF);
    wr(8'h01, 8'h02);
    wr(8'h03, 8'h43);
    check(tim, 22'h35207E);
    wr(8'h01, 8'h00);
    conv_word = {1'b0, 10'h2AB, 1'b1, 10'h0F0};
    for (int f = 0; f < 4; f++) begin
      wr(8'h06, {2'h0, f[1:0], 4'h8});
      tick(14);
      check(last_word, {1'b0, fm(10'h2AB, f[1:0]), 1'b1,
                        fm(10'h0F0, f[1:0])});
    end
    check(clk_term_en, 1'b1);
    wr(8'h06, 8'h50);
    tick(14);
    w1 = last_word;
    tick(1);
    check(last_word, {1'b0, w1.data_a + 10'h001, 1'b0,
                      w1.data_a + 10'h001});
    wr(8'h06, 8'hD0);
    tick(14);
    w1 = last_word;
    tick(1);
    check(last_word, w1.over_a ? {1'b0, 10'h2AA, 1'b0, 10'h2AA} :
                     {1'b1, 10'h155, 1'b1, 10'h155});
    tick(1);
    check(last_word, w1);
    hold = 1'b1;
    n = 0;
    repeat (20) begin
      tick(1);
      n += sample_stall;
    end
    check(22'(n != 0), 22'h000001);
    check(out_valid, 1'b1);
    hold = 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(8'h06, {6'h00, d[1:0]});
      tick(8);
      cnt(16);
      check(22'(n), d == 1 ? 22'd8 :
            (d == 2 ? 22'd4 : 22'd16));
    end
    serial_port_enable = 1'b1;
    divider_select_hi = 1'b1;
    wr(8'h06, 8'h00);
    tick(8);
    cnt(16);
    check(22'(n), 22'd4);
    divider_select_hi = 1'b0;
    divider_select_lo = 1'b1;
    tick(8);
    cnt(16);
    check(22'(n), 22'd8);
    serial_port_enable = 1'b0;
    for (int d = 1; d < 3; d++) begin
      wr(8'h06, {6'h01, d[1:0]});
      tick(8);
      sync_in = 1'b1;
      tick(2 + d);
      check({sample_taken, output_clock}, 2'b00);
      tick(1);
      check({sample_taken, output_clock}, 2'b11);
      sync_in = 1'b0;
      tick(4);
    end
    wr(8'h06, 8'h01);
    tick(8);
    sync_in = 1'b1;
    for (int i = 0; i < 5; i++) begin
      tick(1);
      sv[i] = sample_taken;
    end
    sync_in = 1'b0;
    check({sv[3], sv[4], sv[2], sv[0] ^ sv[1]},
          {sv[0], sv[1], 2'b01});
    wr(8'h06, 8'h55);
    wr(8'h0A, 8'h5B);
    rd(8'h06, 8'h55);
    wr(8'h0A, 8'h5A);
    tick(2);
    rd(8'h06, 8'h00);
    rd(8'h03, 8'hB6);
    rd(8'h08, 8'h00);
    check({clk_term_en, common_mode_cfg}, 9'h000);
    conclude();
  end
endmodule
